/* hw/reset_cause_status_capture.v */
// Reset cause status register with capture logic, event interrupt and register port.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_consts.vh"

module reset_cause_status_capture (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire power_on_cause_in,
    input wire reset_pin_cause_in,
    input wire watchdog_timeout_in,
    input wire watchdog_enable_in,
    input wire pll_unlock_in,
    input wire ext_osc_missing_in,
    input wire clock_monitor_enable_in,
    input wire supply_droop_in,
    input wire supply_droop_reset_enable_in,
    input wire wakeup_source_in,
    input wire low_leakage_stop_mode_in,
    input wire very_low_leakage_stop_mode_in,
    input wire supervisor_in,
    input wire [3:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire wr_en_in,
    input wire rd_en_in,
    output reg [7:0] rd_data_out,
    output reg bus_error_out,
    output reg irq_out,
    output reg capture_done_out,
    output reg [7:0] cause_flags_out
);

    wire [11:0] src_async;
    wire [11:0] src_sync;

    reg [7:0] status_ff;
    reg [7:0] nxt_status;
    reg [7:0] irq_status_ff;
    reg [7:0] nxt_irq_status;
    reg [7:0] irq_mask_ff;
    reg [7:0] nxt_irq_mask;
    reg [1:0] delay_ff;
    reg [1:0] nxt_delay;
    reg captured_ff;
    reg nxt_captured;
    reg [7:0] nxt_rd_data;
    reg nxt_bus_error;

    reg [7:0] cause_vec;
    reg capture_now;
    reg wakeup_valid;
    reg write_ok;
    reg [7:0] clear_bits;

    assign src_async[`RC_SRC_POWER_ON] = power_on_cause_in;
    assign src_async[`RC_SRC_PIN] = reset_pin_cause_in;
    assign src_async[`RC_SRC_WATCHDOG_CAUSE_FLAG_TIMEOUT] = watchdog_timeout_in;
    assign src_async[`RC_SRC_WATCHDOG_CAUSE_FLAG_ENABLE] = watchdog_enable_in;
    assign src_async[`RC_SRC_PLL_UNLOCK] = pll_unlock_in;
    assign src_async[`RC_SRC_OSC_MISSING] = ext_osc_missing_in;
    assign src_async[`RC_SRC_CLK_MON_ENABLE] = clock_monitor_enable_in;
    assign src_async[`RC_SRC_DROOP] = supply_droop_in;
    assign src_async[`RC_SRC_DROOP_RESET_ENABLE] = supply_droop_reset_enable_in;
    assign src_async[`RC_SRC_WAKEUP] = wakeup_source_in;
    assign src_async[`RC_SRC_LLS_MODE] = low_leakage_stop_mode_in;
    assign src_async[`RC_SRC_VERY_LOW_LEAKAGE_STOP_MODE_MODE] = very_low_leakage_stop_mode_in;

    // Cause levels come from the reset generator and power controller, not from this clock.
    reset_source_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .async_in(src_async),
        .sync_out(src_sync)
    );

    // Decode of the cause levels into the flag layout.
    always @* begin
        cause_vec = 8'h00;
        wakeup_valid = 1'b0;
        if (src_sync[`RC_SRC_WAKEUP]) begin
            if (src_sync[`RC_SRC_VERY_LOW_LEAKAGE_STOP_MODE_MODE]) begin
                wakeup_valid = 1'b1;
            end else if (src_sync[`RC_SRC_LLS_MODE] && src_sync[`RC_SRC_PIN]) begin
                wakeup_valid = 1'b1;
            end
        end
        cause_vec[`RC_BIT_POWER_ON] = src_sync[`RC_SRC_POWER_ON];
        cause_vec[`RC_BIT_PIN] = src_sync[`RC_SRC_PIN];
        cause_vec[`RC_BIT_WATCHDOG] = src_sync[`RC_SRC_WATCHDOG_CAUSE_FLAG_TIMEOUT] &
                                      src_sync[`RC_SRC_WATCHDOG_CAUSE_FLAG_ENABLE];
        cause_vec[`RC_BIT_PLL_UNLOCK] = src_sync[`RC_SRC_PLL_UNLOCK];
        cause_vec[`RC_BIT_EXT_OSC_MISSING] = src_sync[`RC_SRC_OSC_MISSING] &
                                             src_sync[`RC_SRC_CLK_MON_ENABLE];
        cause_vec[`RC_BIT_SUPPLY_DROOP] = src_sync[`RC_SRC_POWER_ON] |
                                          (src_sync[`RC_SRC_DROOP] &
                                           src_sync[`RC_SRC_DROOP_RESET_ENABLE]);
        // wakeup flag only for wakeup reset
        cause_vec[`RC_BIT_WAKEUP] = wakeup_valid;
        if (src_sync[`RC_SRC_POWER_ON]) begin
            cause_vec = `RC_STATUS_RESET;
        end
        cause_vec[`RC_BIT_RESERVED] = 1'b0;
    end

    // Capture sequencing: one capture per reset, once the synchronisers hold the levels.
    always @* begin
        nxt_delay = delay_ff;
        nxt_captured = captured_ff;
        capture_now = 1'b0;
        if (!captured_ff) begin
            if (delay_ff == `RC_CAPTURE_DELAY) begin
                capture_now = 1'b1;
                nxt_captured = 1'b1;
            end else begin
                nxt_delay = delay_ff + 2'h1;
            end
        end
    end

    // Status register follows only the capture.
    always @* begin
        nxt_status = status_ff;
        if (capture_now) begin
            nxt_status = cause_vec;
        end
    end

    // Register port write handling.
    always @* begin
        write_ok = wr_en_in & supervisor_in;
        nxt_bus_error = wr_en_in & ~supervisor_in;
        clear_bits = 8'h00;
        nxt_irq_mask = irq_mask_ff;
        if (write_ok && (addr_in == `RC_IRQ_STATUS_OFS)) begin
            clear_bits = wr_data_in & `RC_RESERVED_MASK;
        end
        if (write_ok && (addr_in == `RC_IRQ_MASK_OFS)) begin
            nxt_irq_mask = wr_data_in & `RC_RESERVED_MASK;
        end
        // A capture that lands with a clear keeps its bits set.
        nxt_irq_status = irq_status_ff & ~clear_bits;
        if (capture_now) begin
            nxt_irq_status = nxt_irq_status | cause_vec;
        end
    end

    // Register port read mux; unmapped addresses read zero.
    always @* begin
        nxt_rd_data = 8'h00;
        if (rd_en_in) begin
            case (addr_in)
                `RC_STATUS_OFS: nxt_rd_data = status_ff & `RC_RESERVED_MASK;
                `RC_IRQ_STATUS_OFS: nxt_rd_data = irq_status_ff;
                `RC_IRQ_MASK_OFS: nxt_rd_data = irq_mask_ff;
                default: nxt_rd_data = 8'h00;
            endcase
        end
    end

    // The status holds the power-on pattern through reset, a safe default before capture.
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_ff <= `RC_STATUS_RESET;
            irq_status_ff <= `RC_IRQ_STATUS_RESET;
            irq_mask_ff <= `RC_IRQ_MASK_RESET;
            delay_ff <= 2'h0;
            captured_ff <= 1'b0;
            rd_data_out <= 8'h00;
            bus_error_out <= 1'b0;
            irq_out <= 1'b0;
            capture_done_out <= 1'b0;
            cause_flags_out <= `RC_STATUS_RESET;
        end else begin
            status_ff <= nxt_status;
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
            delay_ff <= nxt_delay;
            captured_ff <= nxt_captured;
            rd_data_out <= nxt_rd_data;
            bus_error_out <= nxt_bus_error;
            irq_out <= |(nxt_irq_status & nxt_irq_mask);
            capture_done_out <= nxt_captured;
            cause_flags_out <= nxt_status;
        end
    end

endmodule // reset_cause_status_capture

`default_nettype wire

/* hw/reset_source_sync.v */
// Two-flip-flop synchronisers for the reset source levels.
`timescale 1ns/1ps
`default_nettype none

module reset_source_sync (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [11:0] async_in,
    output wire [11:0] sync_out
);

    reg [11:0] stage1_ff;
    reg [11:0] stage2_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_sync
            // The first stage feeds only the second, to keep metastability contained.
            always @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stage1_ff[gi] <= 1'b0;
                    stage2_ff[gi] <= 1'b0;
                end else begin
                    stage1_ff[gi] <= async_in[gi];
                    stage2_ff[gi] <= stage1_ff[gi];
                end
            end
        end
    endgenerate

    assign sync_out = stage2_ff;

endmodule // reset_source_sync

`default_nettype wire

/* include/reset_cause_consts.vh */
// Offsets, field positions, reset values and timing counts of the reset cause block.
`ifndef RESET_CAUSE_CONSTS_VH
`define RESET_CAUSE_CONSTS_VH

`define RC_ADDR_W 4
`define RC_DATA_W 8

`define RC_STATUS_OFS 4'h0
`define RC_IRQ_STATUS_OFS 4'h8
`define RC_IRQ_MASK_OFS 4'h9

`define RC_STATUS_RESET 8'h82
`define RC_IRQ_STATUS_RESET 8'h00
`define RC_IRQ_MASK_RESET 8'h00
`define RC_RESERVED_MASK 8'hef

`define RC_BIT_POWER_ON 7
`define RC_BIT_PIN 6
`define RC_BIT_WATCHDOG 5
`define RC_BIT_RESERVED 4
`define RC_BIT_PLL_UNLOCK 3
`define RC_BIT_EXT_OSC_MISSING 2
`define RC_BIT_SUPPLY_DROOP 1
`define RC_BIT_WAKEUP 0

`define RC_NUM_SRC 12
`define RC_SRC_POWER_ON 0
`define RC_SRC_PIN 1
`define RC_SRC_WATCHDOG_CAUSE_FLAG_TIMEOUT 2
`define RC_SRC_WATCHDOG_CAUSE_FLAG_ENABLE 3
`define RC_SRC_PLL_UNLOCK 4
`define RC_SRC_OSC_MISSING 5
`define RC_SRC_CLK_MON_ENABLE 6
`define RC_SRC_DROOP 7
`define RC_SRC_DROOP_RESET_ENABLE 8
`define RC_SRC_WAKEUP 9
`define RC_SRC_LLS_MODE 10
`define RC_SRC_VERY_LOW_LEAKAGE_STOP_MODE_MODE 11

`define RC_CAPTURE_DELAY 2'h2

`endif

/* tb/reset_cause_assertions.sv */
// Checker for the reset cause status block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_checker (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic supervisor_in,
    input wire logic [3:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_data_out,
    input wire logic bus_error_out,
    input wire logic capture_done_out,
    input wire logic [7:0] cause_flags_out
);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!rst_n_in);
a_read_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 8'h00)
    else $error("read data not zero outside a read");
a_reserved_bit_zero: assert property (cause_flags_out[4] == 1'b0)
    else $error("reserved flag set");
a_status_read_value: assert property ($past(rd_en_in) && $past(addr_in) == 4'h0
    |-> rd_data_out == $past(cause_flags_out))
    else $error("status read differs from flags");
a_flags_hold: assert property (capture_done_out && $past(capture_done_out)
    |-> $stable(cause_flags_out))
    else $error("flags changed after capture");
a_bus_error_pulse: assert property (bus_error_out ==
    ($past(wr_en_in) && !$past(supervisor_in)))
    else $error("bus error does not follow user write");
a_power_on_exact: assert property (cause_flags_out[7] |-> cause_flags_out == 8'h82)
    else $error("power-on flags not exact");
a_capture_time: assert property ($rose(rst_n_in)
    |-> !capture_done_out ##1 !capture_done_out ##1 !capture_done_out ##1 capture_done_out)
    else $error("capture not at third edge");
a_unmapped_zero: assert property ($past(rd_en_in)
    && !($past(addr_in) inside {4'h0, 4'h8, 4'h9}) |-> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
endmodule // reset_cause_checker
bind reset_cause_status_capture reset_cause_checker chk_inst (.clk_sys_in, .rst_n_in,
    .supervisor_in, .addr_in, .wr_en_in, .rd_en_in, .rd_data_out, .bus_error_out,
    .capture_done_out, .cause_flags_out);
`default_nettype wire

/* tb/tb.sv */
// Register-level testbench for the reset cause status block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [11:0] src = 12'h000;
    logic supervisor_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic [7:0] rd_data_out;
    logic [7:0] cause_flags_out;
    logic bus_error_out;
    logic irq_out;
    logic capture_done_out;
    int errors = 0;
    int checks_done = 0;
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    reset_cause_status_capture reset_cause_status_capture_inst (.clk_sys_in, .rst_n_in,
        .power_on_cause_in(src[0]), .reset_pin_cause_in(src[1]),
        .watchdog_timeout_in(src[2]), .watchdog_enable_in(src[3]), .pll_unlock_in(src[4]),
        .ext_osc_missing_in(src[5]), .clock_monitor_enable_in(src[6]),
        .supply_droop_in(src[7]), .supply_droop_reset_enable_in(src[8]),
        .wakeup_source_in(src[9]), .low_leakage_stop_mode_in(src[10]),
        .very_low_leakage_stop_mode_in(src[11]), .supervisor_in, .addr_in, .wr_data_in,
        .wr_en_in, .rd_en_in, .rd_data_out, .bus_error_out, .irq_out, .capture_done_out,
        .cause_flags_out);
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_en_in <= 1'b0;
        #1 check(rd_data_out, exp);
    endtask
    // A refused write must still answer with a one-cycle error pulse.
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic sv);
        @(posedge clk_sys_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        supervisor_in <= sv;
        @(posedge clk_sys_in);
        wr_en_in <= 1'b0;
        #1 check({7'h00, bus_error_out}, {7'h00, ~sv});
    endtask
    // Sources are set while reset is low and kept stable until the capture.
    task automatic cause_reset(input logic [11:0] s, input logic [7:0] exp);
        int n;
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        src <= s;
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        n = 0;
        while (capture_done_out !== 1'b1 && n < 10) begin
            @(posedge clk_sys_in);
            #1 n++;
        end
        if (n >= 10) begin
            errors++;
            end_of_test();
        end
        check(cause_flags_out, exp);
        rd_chk(4'h0, exp);
    endtask
    // Source bits: 0 power-on, 1 pin, 2-3 watchdog timeout/enable, 4 pll, 5-6 osc/monitor,
    // 7-8 droop/enable, 9 wakeup, 10 low leakage stop, 11 very low leakage stop.
    initial begin
        cause_reset(12'h001, 8'h82);
        cause_reset(12'h183, 8'h82);
        cause_reset(12'h180, 8'h02);
        cause_reset(12'h080, 8'h00);
        cause_reset(12'ha02, 8'h41);
        cause_reset(12'ha00, 8'h01);
        cause_reset(12'h600, 8'h00);
        cause_reset(12'h602, 8'h41);
        cause_reset(12'h00c, 8'h20);
        cause_reset(12'h004, 8'h00);
        cause_reset(12'h010, 8'h08);
        cause_reset(12'h060, 8'h04);
        cause_reset(12'h020, 8'h00);
        cause_reset(12'h002, 8'h40);
        cause_reset(12'h07e, 8'h6c);
        check({7'h00, irq_out}, 8'h00);
        // Sources that change after the capture must leave the flags alone.
        @(posedge clk_sys_in);
        src <= 12'h001;
        repeat (4) @(posedge clk_sys_in);
        #1 check(cause_flags_out, 8'h6c);
        wr_reg(4'h0, 8'h93, 1'b1);
        rd_chk(4'h0, 8'h6c);
        wr_reg(4'h0, 8'hff, 1'b0);
        rd_chk(4'h0, 8'h6c);
        rd_chk(4'h8, 8'h6c);
        wr_reg(4'h9, 8'hff, 1'b0);
        rd_chk(4'h9, 8'h00);
        wr_reg(4'h9, 8'hff, 1'b1);
        check({7'h00, irq_out}, 8'h01);
        rd_chk(4'h9, 8'hef);
        wr_reg(4'h8, 8'h6c, 1'b1);
        check({7'h00, irq_out}, 8'h00);
        rd_chk(4'h8, 8'h00);
        wr_reg(4'h3, 8'h55, 1'b1);
        rd_chk(4'h3, 8'h00);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
